// ---- rtl/qas_pkg.sv ----
package qas_pkg;
  // Register indices (word addresses on the plain port)
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h01;
  localparam logic [7:0] ADDR_STAT = 8'h02;
  localparam logic [7:0] ADDR_PRESC = 8'h03;
  localparam logic [7:0] ADDR_CMD_BASE = 8'h40;
  localparam logic [7:0] ADDR_RES_BASE = 8'h80;
  // Control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_SSE_BIT = 3;
  localparam int CTL_RESUME_BIT = 4;
  localparam int CTL_BQ2_LSB = 8;
  // Queue modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SW_SINGLE = 3'h1;
  localparam logic [2:0] MODE_EXT_SINGLE = 3'h2;
  localparam logic [2:0] MODE_EXT_CONT = 3'h3;
  localparam logic [2:0] MODE_SW_CONT = 3'h4;
  // Command entry layout: [5:0] chan, [7:6] final sample select, [8] bypass, [9] pause
  localparam int CMD_CHAN_LSB = 0;
  localparam int CMD_FSS_LSB = 6;
  localparam int CMD_BYP_BIT = 8;
  localparam int CMD_PAUSE_BIT = 9;
  localparam logic [5:0] END_OF_LIST_CODE = 6'h3f;
  localparam logic [5:0] REFERENCE_LOW_CHANNEL = 6'h3c;
  localparam logic [5:0] REFERENCE_HIGH_CHANNEL = 6'h3d;
  localparam logic [5:0] HALF_ANALOG_SUPPLY_CHANNEL = 6'h3e;
  localparam int NUM_EXT_INPUTS = 16;
  localparam int TABLE_ENTRIES = 40;
  localparam int RESULT_BITS = 10;
  // Timing in converter clocks, then register reset values
  localparam int INIT_SAMPLE_CLKS = 2;
  localparam int TRANSFER_CLKS = 4;
  localparam int BYPASS_MIN_FINAL_CLKS = 4;
  localparam logic [7:0] PRESC_RESET = 8'h17;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] BQ2_RESET = 32'h0000_1400;
  // Status bits
  localparam int ST_Q1_DONE = 0;
  localparam int ST_Q1_PAUSE = 1;
  localparam int ST_Q2_DONE = 2;
  localparam int ST_Q2_PAUSE = 3;
  localparam int ST_Q1_OVR = 4;
  localparam int ST_Q2_OVR = 5;
  localparam int ST_Q2_PEND = 6;
  localparam int ST_Q2_SUSP = 7;
  localparam int ST_ACTIVE_LSB = 8;

  typedef struct packed {
    logic pause;
    logic bypass;
    logic [1:0] finalSel;
    logic [5:0] chan;
  } qas_cmd_t;

  typedef struct packed {
    logic sampleInit;
    logic transfer;
    logic sampleFinal;
    logic [RESULT_BITS-1:0] dacCode;
    logic [5:0] chan;
  } qas_afe_t;
endpackage

// ---- rtl/qas_conv_engine.sv ----
module qas_conv_engine #(
  parameter int RES_BITS = qas_pkg::RESULT_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic convTick,
  input wire logic start,
  input wire logic abort,
  input wire qas_pkg::qas_cmd_t cmd,
  input wire logic cmpHigh,
  output qas_pkg::qas_afe_t afe,
  output logic busy,
  output logic done,
  output logic [RES_BITS-1:0] result
);
  initial
  begin
    if (RES_BITS < 2 || RES_BITS > 16)
      $error("RES_BITS out of range");
  end

  typedef enum logic [2:0] {
    QCE_IDLE = 3'b000, QCE_INIT = 3'b001, QCE_XFER = 3'b010,
    QCE_FINAL = 3'b011, QCE_RESOLVE = 3'b100
  } qas_ce_state_t;

  qas_ce_state_t state_reg;
  logic [4:0] count_reg;
  logic [RES_BITS-1:0] sar_reg;
  logic [RES_BITS-1:0] trial_reg;
  logic [5:0] chan_reg;
  logic done_reg;
  logic [4:0] finalLen;

  // Bypass needs at least four final clocks, so the shortest selection is stretched
  always_comb
  begin
    finalLen = 5'(2 << cmd.finalSel);
    if (cmd.bypass && finalLen < 5'(qas_pkg::BYPASS_MIN_FINAL_CLKS))
      finalLen = 5'(qas_pkg::BYPASS_MIN_FINAL_CLKS);
  end

  logic [4:0] finalLen_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= QCE_IDLE;
      count_reg <= 5'h0;
      sar_reg <= '0;
      trial_reg <= '0;
      chan_reg <= 6'h0;
      finalLen_reg <= 5'h0;
    end
    else if (abort)
      state_reg <= QCE_IDLE;
    else if (start && state_reg == QCE_IDLE)
    begin
      chan_reg <= cmd.chan;
      finalLen_reg <= finalLen;
      count_reg <= 5'h0;
      sar_reg <= '0;
      trial_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
      // Bypass skips the six clocks of initial sample and transfer
      state_reg <= cmd.bypass ? QCE_FINAL : QCE_INIT;
    end
    else if (convTick)
    begin
      unique case (state_reg)
        QCE_IDLE: ;
        QCE_INIT:
          if (count_reg == 5'(qas_pkg::INIT_SAMPLE_CLKS - 1))
          begin
            count_reg <= 5'h0;
            state_reg <= QCE_XFER;
          end
          else
            count_reg <= count_reg + 5'h1;
        QCE_XFER:
          if (count_reg == 5'(qas_pkg::TRANSFER_CLKS - 1))
          begin
            count_reg <= 5'h0;
            state_reg <= QCE_FINAL;
          end
          else
            count_reg <= count_reg + 5'h1;
        QCE_FINAL:
          if (count_reg == finalLen_reg - 5'h1)
          begin
            count_reg <= 5'h0;
            state_reg <= QCE_RESOLVE;
          end
          else
            count_reg <= count_reg + 5'h1;
        QCE_RESOLVE:
        begin
          // One decision per bit, MSB first; trial bit walks down
          if (!cmpHigh)
            sar_reg <= sar_reg | trial_reg;
          trial_reg <= trial_reg >> 1;
          if (count_reg == 5'(RES_BITS - 1))
            state_reg <= QCE_IDLE;
          else
            count_reg <= count_reg + 5'h1;
        end
        default: state_reg <= QCE_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      done_reg <= 1'b0;
    else
      done_reg <= !abort && convTick && state_reg == QCE_RESOLVE
        && count_reg == 5'(RES_BITS - 1);
  end

  assign done = done_reg;
  assign result = sar_reg;
  assign busy = state_reg != QCE_IDLE;
  assign afe.sampleInit = state_reg == QCE_INIT;
  assign afe.transfer = state_reg == QCE_XFER;
  assign afe.sampleFinal = state_reg == QCE_FINAL;
  assign afe.dacCode = sar_reg | trial_reg;
  assign afe.chan = chan_reg;
endmodule // qas_conv_engine

// ---- rtl/qas_sequencer.sv ----
module qas_sequencer #(
  parameter int ENTRIES = qas_pkg::TABLE_ENTRIES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic extTrig1,
  input wire logic extTrig2,
  input wire logic cmpHigh,
  output qas_pkg::qas_afe_t afe,
  output logic [4:0] muxSel,
  output logic refSel
);
  initial
  begin
    if (ENTRIES < 2 || ENTRIES > 63)
      $error("ENTRIES out of range");
  end

  typedef enum logic [1:0] {
    QAS_IDLE = 2'b00, QAS_RUN = 2'b01, QAS_PAUSED = 2'b10, QAS_SUSP = 2'b11
  } qas_qstate_t;

  // Tables; width fixed by the entry layout
  logic [9:0] cmdTable [ENTRIES];
  logic [9:0] resTable [ENTRIES];

  logic [31:0] ctrl1_reg, ctrl2_reg;
  logic [7:0] presc_reg, prescCnt_reg;
  logic convTick;
  qas_qstate_t q1_reg, q2_reg;
  logic [5:0] ptr1_reg, ptr2_reg, cur_reg;
  logic q1Done_reg, q1Pause_reg, q2Done_reg, q2Pause_reg;
  logic q1Ovr_reg, q2Ovr_reg, q2Pend_reg;
  logic ext1_reg, ext2_reg;
  logic convOn_reg, convQ2_reg;
  logic [31:0] rdData_reg;

  function automatic logic [5:0] bq2Of(input logic [31:0] c2);
    bq2Of = c2[qas_pkg::CTL_BQ2_LSB +: 6];
  endfunction

  // Trigger for a queue given its mode and edge of external input
  function automatic logic trigOf(input logic [31:0] c, input logic extEdge);
    logic [2:0] m;
    m = c[qas_pkg::CTL_MODE_LSB +: 3];
    unique case (m)
      qas_pkg::MODE_SW_SINGLE: trigOf = c[qas_pkg::CTL_SSE_BIT];
      qas_pkg::MODE_EXT_SINGLE: trigOf = c[qas_pkg::CTL_SSE_BIT] && extEdge;
      qas_pkg::MODE_EXT_CONT: trigOf = extEdge;
      qas_pkg::MODE_SW_CONT: trigOf = 1'b1;
      default: trigOf = 1'b0;
    endcase
  endfunction

  function automatic logic isCont(input logic [31:0] c);
    isCont = c[qas_pkg::CTL_MODE_LSB +: 3] == qas_pkg::MODE_EXT_CONT
      || c[qas_pkg::CTL_MODE_LSB +: 3] == qas_pkg::MODE_SW_CONT;
  endfunction

  // Converter clock enable from the module clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prescCnt_reg <= 8'h0;
    else if (prescCnt_reg >= presc_reg)
      prescCnt_reg <= 8'h0;
    else
      prescCnt_reg <= prescCnt_reg + 8'h1;
  end
  assign convTick = prescCnt_reg >= presc_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext1_reg <= 1'b0;
      ext2_reg <= 1'b0;
    end
    else
    begin
      ext1_reg <= extTrig1;
      ext2_reg <= extTrig2;
    end
  end

  // Mode chooses trigger source per queue; an external trigger needs a fresh rising edge after each pause
  logic trig1, trig2;
  assign trig1 = trigOf(ctrl1_reg, extTrig1 && !ext1_reg);
  assign trig2 = trigOf(ctrl2_reg, extTrig2 && !ext2_reg);

  // End of a queue: table end, queue two start (for queue one) or the end code
  logic [5:0] ptrX;
  logic q1Sel, endHit;
  qas_pkg::qas_cmd_t curCmd;
  assign q1Sel = q1_reg == QAS_RUN;
  assign ptrX = q1Sel ? ptr1_reg : ptr2_reg;
  assign curCmd = (ptrX < 6'(ENTRIES)) ? cmdTable[ptrX] : '1;
  assign endHit = ptrX >= 6'(ENTRIES) || (q1Sel && ptrX == bq2Of(ctrl2_reg))
    || curCmd.chan == qas_pkg::END_OF_LIST_CODE;

  logic engBusy, engDone, engStart, engAbort;
  logic [9:0] engResult;
  qas_pkg::qas_cmd_t engCmd;
  logic running;
  assign running = q1Sel || q2_reg == QAS_RUN;
  assign engStart = running && !convOn_reg && !endHit;
  // Queue one trigger pre-empts a running queue two conversion
  assign engAbort = convOn_reg && convQ2_reg && trig1 && q1_reg != QAS_RUN;
  assign engCmd = curCmd;

  qas_conv_engine #(.RES_BITS(qas_pkg::RESULT_BITS)) u_eng (
    .clk(clk),
    .rst(rst),
    .convTick(convTick),
    .start(engStart && !engAbort),
    .abort(engAbort),
    .cmd(engCmd),
    .cmpHigh(cmpHigh),
    .afe(afe),
    .busy(engBusy),
    .done(engDone),
    .result(engResult)
  );

  // Channel codes 0..15 external, three references above
  assign muxSel = afe.chan[4:0];
  assign refSel = afe.chan >= qas_pkg::REFERENCE_LOW_CHANNEL
    && afe.chan <= qas_pkg::HALF_ANALOG_SUPPLY_CHANNEL;

  logic finish, fin1, fin2, endNow, pauseNow;
  assign finish = convOn_reg && engDone;
  assign fin1 = finish && !convQ2_reg;
  assign fin2 = finish && convQ2_reg;
  assign endNow = running && !convOn_reg && endHit;
  assign pauseNow = finish && cmdTable[cur_reg][qas_pkg::CMD_PAUSE_BIT];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      convOn_reg <= 1'b0;
      convQ2_reg <= 1'b0;
      cur_reg <= 6'h0;
    end
    else if (engAbort || finish)
      convOn_reg <= 1'b0;
    else if (engStart)
    begin
      convOn_reg <= 1'b1;
      convQ2_reg <= !q1Sel;
      cur_reg <= ptrX;
    end
  end

  always_ff @(posedge clk)
  begin
    if (finish)
      resTable[cur_reg] <= engResult;
  end

  // Queue one: start, pause, completion
  logic q1Starts;
  assign q1Starts = trig1 && q1_reg != QAS_RUN
    && !(q1_reg == QAS_IDLE && q1Done_reg && !isCont(ctrl1_reg)
    && ctrl1_reg[qas_pkg::CTL_MODE_LSB +: 3] != qas_pkg::MODE_SW_SINGLE
    && !ctrl1_reg[qas_pkg::CTL_SSE_BIT]);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q1_reg <= QAS_IDLE;
      ptr1_reg <= 6'h0;
    end
    else if (ctrl1_reg[qas_pkg::CTL_MODE_LSB +: 3] == qas_pkg::MODE_OFF)
      q1_reg <= QAS_IDLE;
    else if (q1Sel && endNow)
    begin
      q1_reg <= QAS_IDLE;
      ptr1_reg <= 6'h0;
    end
    else if (fin1)
    begin
      ptr1_reg <= ptr1_reg + 6'h1;
      if (pauseNow)
        q1_reg <= QAS_PAUSED;
    end
    else if (q1Starts)
    begin
      q1_reg <= QAS_RUN;
      if (q1_reg == QAS_IDLE)
        ptr1_reg <= 6'h0;
    end
  end

  // Queue two arbitration
  logic q1Yields, q2Blocked, q2Starts;
  assign q1Yields = q1_reg != QAS_RUN && !q1Starts;
  assign q2Blocked = q1_reg == QAS_RUN || q1Starts;
  assign q2Starts = (trig2 || q2Pend_reg) && q2_reg != QAS_RUN && q2_reg != QAS_SUSP;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q2_reg <= QAS_IDLE;
      ptr2_reg <= 6'h0;
    end
    else if (ctrl2_reg[qas_pkg::CTL_MODE_LSB +: 3] == qas_pkg::MODE_OFF)
      q2_reg <= QAS_IDLE;
    else if (engAbort || (q2_reg == QAS_RUN && q1Starts))
      q2_reg <= QAS_SUSP;
    else if (!q1Sel && q2_reg == QAS_RUN && endNow)
      q2_reg <= QAS_IDLE;
    else if (fin2)
    begin
      ptr2_reg <= ptr2_reg + 6'h1;
      if (pauseNow)
        q2_reg <= QAS_PAUSED;
    end
    else if (q2_reg == QAS_SUSP && q1Yields)
    begin
      q2_reg <= QAS_RUN;
      if (!ctrl2_reg[qas_pkg::CTL_RESUME_BIT])
        ptr2_reg <= bq2Of(ctrl2_reg);
    end
    else if (q2Starts && !q2Blocked)
    begin
      q2_reg <= QAS_RUN;
      if (q2_reg == QAS_IDLE)
        ptr2_reg <= bq2Of(ctrl2_reg);
    end
  end

  // Sticky status; hardware set wins over software clear
  logic stWr;
  logic [31:0] clr;
  assign stWr = wrEn && addr == qas_pkg::ADDR_STAT;
  assign clr = stWr ? wrData : 32'h0;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q1Done_reg <= 1'b0;
      q1Pause_reg <= 1'b0;
      q2Done_reg <= 1'b0;
      q2Pause_reg <= 1'b0;
      q1Ovr_reg <= 1'b0;
      q2Ovr_reg <= 1'b0;
      q2Pend_reg <= 1'b0;
    end
    else
    begin
      q1Done_reg <= (q1Sel && endNow) || (q1Done_reg && !clr[qas_pkg::ST_Q1_DONE]);
      q2Done_reg <= (!q1Sel && endNow) || (q2Done_reg && !clr[qas_pkg::ST_Q2_DONE]);
      q1Pause_reg <= (fin1 && pauseNow) || (q1Pause_reg && !clr[qas_pkg::ST_Q1_PAUSE]);
      q2Pause_reg <= (fin2 && pauseNow) || (q2Pause_reg && !clr[qas_pkg::ST_Q2_PAUSE]);
      // Software single-scan never reports overrun
      q1Ovr_reg <= (trig1 && q1_reg == QAS_RUN
        && ctrl1_reg[qas_pkg::CTL_MODE_LSB +: 3] != qas_pkg::MODE_SW_SINGLE
        && ctrl1_reg[qas_pkg::CTL_MODE_LSB +: 3] != qas_pkg::MODE_SW_CONT)
        || (q1Ovr_reg && !clr[qas_pkg::ST_Q1_OVR]);
      q2Ovr_reg <= (trig2 && (q2Pend_reg || q2_reg == QAS_SUSP
        || q2_reg == QAS_RUN)
        && ctrl2_reg[qas_pkg::CTL_MODE_LSB +: 3] != qas_pkg::MODE_SW_SINGLE
        && ctrl2_reg[qas_pkg::CTL_MODE_LSB +: 3] != qas_pkg::MODE_SW_CONT)
        || (q2Ovr_reg && !clr[qas_pkg::ST_Q2_OVR]);
      if (q2Starts && q2Blocked && q2_reg != QAS_SUSP)
        q2Pend_reg <= 1'b1;
      else if ((q2Starts && !q2Blocked) || clr[qas_pkg::ST_Q2_PEND])
        q2Pend_reg <= 1'b0;
    end
  end

  // Control registers; single-scan enable self-clears at end of queue
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_reg <= qas_pkg::CTRL_RESET;
      ctrl2_reg <= qas_pkg::BQ2_RESET;
      presc_reg <= qas_pkg::PRESC_RESET;
    end
    else
    begin
      if (wrEn && addr == qas_pkg::ADDR_CTRL1)
        ctrl1_reg <= wrData;
      // Kept through pauses, else a paused single-scan queue could never resume
      else if (q1Sel && endNow)
        ctrl1_reg[qas_pkg::CTL_SSE_BIT] <= 1'b0;
      if (wrEn && addr == qas_pkg::ADDR_CTRL2)
        ctrl2_reg <= wrData;
      else if (!q1Sel && endNow)
        ctrl2_reg[qas_pkg::CTL_SSE_BIT] <= 1'b0;
      if (wrEn && addr == qas_pkg::ADDR_PRESC)
        presc_reg <= wrData[7:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (wrEn && addr >= qas_pkg::ADDR_CMD_BASE
      && addr < qas_pkg::ADDR_CMD_BASE + 8'(ENTRIES))
      cmdTable[6'(addr - qas_pkg::ADDR_CMD_BASE)] <= wrData[9:0];
  end

  function automatic logic q2Susp(input qas_qstate_t s);
    q2Susp = s == QAS_SUSP;
  endfunction

  logic [31:0] rdNext;
  always_comb
  begin
    rdNext = 32'h0;
    if (addr == qas_pkg::ADDR_CTRL1)
      rdNext = ctrl1_reg & ~(32'h1 << qas_pkg::CTL_SSE_BIT);
    else if (addr == qas_pkg::ADDR_CTRL2)
      rdNext = ctrl2_reg & ~(32'h1 << qas_pkg::CTL_SSE_BIT);
    else if (addr == qas_pkg::ADDR_PRESC)
      rdNext = {24'h0, presc_reg};
    else if (addr == qas_pkg::ADDR_STAT)
      rdNext = {20'h0, q2_reg, q1_reg, q2Susp(q2_reg), q2Pend_reg, q2Ovr_reg,
        q1Ovr_reg, q2Pause_reg, q2Done_reg, q1Pause_reg, q1Done_reg};
    else if (addr >= qas_pkg::ADDR_CMD_BASE && addr < qas_pkg::ADDR_CMD_BASE + 8'(ENTRIES))
      rdNext = {22'h0, cmdTable[6'(addr - qas_pkg::ADDR_CMD_BASE)]};
    else if (addr >= qas_pkg::ADDR_RES_BASE && addr < qas_pkg::ADDR_RES_BASE + 8'(ENTRIES))
      rdNext = {22'h0, resTable[6'(addr - qas_pkg::ADDR_RES_BASE)]};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData_reg <= 32'h0;
    else if (rdEn)
      rdData_reg <= rdNext;
    else
      rdData_reg <= 32'h0;
  end
  assign rdData = rdData_reg;
endmodule // qas_sequencer

// ---- bench/qas_afe_model.sv ----
module qas_afe_model (
  input wire qas_pkg::qas_afe_t afe,
  output logic cmpHigh
);
  timeunit 1ns;
  timeprecision 1ps;
  // Input level per channel is {chan, 4'ha}, so the bench can predict every result
  // An exact match keeps the bit, so the final code equals the level
  assign cmpHigh = afe.dacCode > {afe.chan, 4'ha};
endmodule // qas_afe_model

// ---- bench/qas_sequencer_sva.sv ----
module qas_sequencer_sva #(
  parameter int ENTRIES = qas_pkg::TABLE_ENTRIES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] rdData,
  input wire logic extTrig1,
  input wire logic extTrig2,
  input wire logic cmpHigh,
  input wire qas_pkg::qas_afe_t afe,
  input wire logic [4:0] muxSel,
  input wire logic refSel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_ref_sel;
    refSel == (afe.chan >= 6'h3c && afe.chan <= 6'h3e);
  endproperty
  a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");
  property p_mux_sel;
    muxSel == afe.chan[4:0];
  endproperty
  a_mux_sel: assert property (p_mux_sel) else $error("mux select wrong");
  property p_phase_one;
    $onehot0({afe.sampleInit, afe.transfer, afe.sampleFinal});
  endproperty
  a_phase_one: assert property (p_phase_one) else $error("phases overlap");
  property p_init_len;
    $rose(afe.sampleInit) |-> afe.sampleInit [*2];
  endproperty
  a_init_len: assert property (p_init_len) else $error("initial sample short");
  property p_xfer_len;
    $rose(afe.transfer) |-> afe.transfer [*4];
  endproperty
  a_xfer_len: assert property (p_xfer_len) else $error("transfer short");
  property p_final_len;
    $rose(afe.sampleFinal) |-> afe.sampleFinal [*2];
  endproperty
  a_final_len: assert property (p_final_len) else $error("final sample short");
  // Bypass shows as a final phase not preceded by transfer
  property p_byp_final;
    $rose(afe.sampleFinal) && !$past(afe.transfer) |-> afe.sampleFinal [*4];
  endproperty
  a_byp_final: assert property (p_byp_final) else $error("bypass final short");
  property p_msb_first;
    $fell(afe.sampleFinal) |-> ##[0:2] afe.dacCode == 10'h200;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not MSB");
  property p_rd_idle;
    !$past(rdEn) |-> rdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  c_bypass: cover property ($rose(afe.sampleFinal) && !$past(afe.transfer));
  c_ref: cover property (refSel && afe.sampleFinal);
  c_resolve: cover property ($fell(afe.sampleFinal));
endmodule // qas_sequencer_sva
bind qas_sequencer qas_sequencer_sva #(.ENTRIES(ENTRIES)) u_sva (.clk(clk), .rst(rst),
  .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
  .extTrig1(extTrig1), .extTrig2(extTrig2), .cmpHigh(cmpHigh), .afe(afe),
  .muxSel(muxSel), .refSel(refSel));

// ---- bench/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CB = qas_pkg::ADDR_CMD_BASE;
  localparam logic [7:0] RB = qas_pkg::ADDR_RES_BASE;
  localparam logic [7:0] ST = qas_pkg::ADDR_STAT;
  logic clk, rst, wrEn, rdEn, extTrig1, extTrig2, cmpHigh, refSel;
  logic [7:0] addr;
  logic [31:0] wrData, rdData, s;
  logic [4:0] muxSel;
  qas_pkg::qas_afe_t afe;
  int error_cnt = 0;
  int cmp_count = 0;
  qas_sequencer #(.ENTRIES(40)) u_dut (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .extTrig1(extTrig1), .extTrig2(extTrig2),
    .cmpHigh(cmpHigh), .afe(afe), .muxSel(muxSel), .refSel(refSel));
  qas_afe_model u_afe (.afe(afe), .cmpHigh(cmpHigh));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lvl(input logic [5:0] c);
    return {22'h0, c, 4'ha};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 d = rdData;
  endtask
  // Polling keeps the wait bounded; each read costs two cycles
  task automatic wait_bit(input int b);
    s = '0;
    for (int i = 0; i < 3000 && s[b] !== 1'b1; i++)
      rd(ST, s);
    chk({31'h0, s[b]}, 32'h1);
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    error_cnt++;
    stop_test();
  end
  initial
  begin
    rst = 1'b1;
    addr = 8'h0;
    wrData = 32'h0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    extTrig1 = 1'b0;
    extTrig2 = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(qas_pkg::ADDR_CTRL1, s);
    chk(s, qas_pkg::CTRL_RESET);
    rd(qas_pkg::ADDR_CTRL2, s);
    chk(s, qas_pkg::BQ2_RESET);
    rd(qas_pkg::ADDR_PRESC, s);
    chk(s, {24'h0, qas_pkg::PRESC_RESET});
    rd(8'h10, s);
    chk(s, 32'h0);
    // Fastest converter clock keeps the run short
    wr(qas_pkg::ADDR_PRESC, 32'h0);
    wr(CB, 32'h005);
    // Shortest final select on a bypass entry, so the stretch is exercised
    wr(CB + 8'd1, 32'h13d);
    wr(CB + 8'd2, 32'h03f);
    wr(CB + 8'd20, 32'h002);
    wr(CB + 8'd21, 32'h003);
    wr(CB + 8'd22, 32'h03f);
    wr(qas_pkg::ADDR_CTRL1, 32'h9);
    wait_bit(qas_pkg::ST_Q1_DONE);
    rd(RB, s);
    chk(s, lvl(6'h05));
    rd(RB + 8'd1, s);
    chk(s, lvl(6'h3d));
    wr(ST, 32'hff);
    rd(ST, s);
    chk(s & 32'hff, 32'h0);
    wr(CB, 32'h205);
    wr(qas_pkg::ADDR_CTRL2, 32'h140a);
    wr(qas_pkg::ADDR_CTRL1, 32'ha);
    @(posedge clk);
    extTrig2 <= 1'b1;
    // Abort lands in resolution so the phase checks stay meaningful
    // Only the first resolve cycle shows the MSB trial with all phases low
    for (int i = 0; i < 500 && !(afe.dacCode === 10'h200 && afe.chan === 6'h02
      && {afe.sampleInit, afe.transfer, afe.sampleFinal} === 3'b000); i++)
      @(negedge clk);
    @(posedge clk);
    extTrig1 <= 1'b1;
    wait_bit(qas_pkg::ST_Q2_SUSP);
    @(posedge clk);
    extTrig2 <= 1'b0;
    @(posedge clk);
    extTrig2 <= 1'b1;
    wait_bit(qas_pkg::ST_Q2_OVR);
    wait_bit(qas_pkg::ST_Q1_PAUSE);
    wait_bit(qas_pkg::ST_Q2_DONE);
    rd(RB + 8'd20, s);
    chk(s, lvl(6'h02));
    rd(RB + 8'd21, s);
    chk(s, lvl(6'h03));
    // New channel in entry one shows whether the next subqueue really ran
    wr(CB + 8'd1, 32'h13e);
    @(posedge clk);
    extTrig1 <= 1'b0;
    @(posedge clk);
    extTrig1 <= 1'b1;
    wait_bit(qas_pkg::ST_Q1_DONE);
    rd(RB + 8'd1, s);
    chk(s, lvl(6'h3e));
    // Both triggers in one cycle, then a second queue two trigger
    wr(qas_pkg::ADDR_CTRL1, 32'ha);
    wr(qas_pkg::ADDR_CTRL2, 32'h140a);
    wr(ST, 32'hff);
    @(posedge clk);
    extTrig1 <= 1'b0;
    extTrig2 <= 1'b0;
    @(posedge clk);
    extTrig1 <= 1'b1;
    extTrig2 <= 1'b1;
    @(posedge clk);
    extTrig2 <= 1'b0;
    @(posedge clk);
    extTrig2 <= 1'b1;
    rd(ST, s);
    chk(s & 32'h60, 32'h60);
    wait_bit(qas_pkg::ST_Q2_DONE);
    rd(ST, s);
    chk(s & 32'h40, 32'h0);
    // Continuous scan: finish the paused queue, then restart at entry zero
    wr(qas_pkg::ADDR_CTRL1, 32'h3);
    wr(CB, 32'h206);
    wr(ST, 32'hff);
    @(posedge clk);
    extTrig1 <= 1'b0;
    @(posedge clk);
    extTrig1 <= 1'b1;
    wait_bit(qas_pkg::ST_Q1_DONE);
    @(posedge clk);
    extTrig1 <= 1'b0;
    @(posedge clk);
    extTrig1 <= 1'b1;
    wait_bit(qas_pkg::ST_Q1_PAUSE);
    rd(RB, s);
    chk(s, lvl(6'h06));
    stop_test();
  end
endmodule // tb
